// ---- inc/ramp_pkg.sv ----
// constants and types shared by the ramp controller files
package ramp_pkg;
   // ***********************************************
   // register byte offsets
   // ***********************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_MODE = 8'h04;
   localparam logic [7:0] ADDR_TOP = 8'h08;
   localparam logic [7:0] ADDR_START = 8'h0c;
   localparam logic [7:0] ADDR_URATE = 8'h10;
   localparam logic [7:0] ADDR_DRATE = 8'h14;
   localparam logic [7:0] ADDR_SACC = 8'h18;
   localparam logic [7:0] ADDR_SDEC = 8'h1c;
   localparam logic [7:0] ADDR_MOVE = 8'h20;
   localparam logic [7:0] ADDR_MULT = 8'h24;
   localparam logic [7:0] ADDR_SPEED = 8'h28;
   localparam logic [7:0] ADDR_REMAIN = 8'h2c;
   // ***********************************************
   // field positions
   // ***********************************************
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_STOP_BIT = 1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_CORR_BIT = 1;
   localparam int MODE_S_BIT = 0;
   localparam int MODE_CORR_OFF_BIT = 1;
   localparam int MODE_IDLE_LSB = 4;
   localparam int MODE_IDLE_MSB = 6;
   // ***********************************************
   // timing
   // ***********************************************
   localparam logic [2:0] IDLE_MIN = 3'h2;
   // linear step period is (rate + 1) * 4 clocks, doubled in s zones
   localparam int STEP_SHIFT = 2;
   // ***********************************************
   // types
   // ***********************************************
   typedef enum logic [1:0] {PH_IDLE, PH_LEAD, PH_RUN} phase_t;
endpackage

// ---- rtl/pulse_gen.sv ----
// pulse rate generator: prescaler plus 16-bit phase accumulator
`timescale 1ns/1ps
module pulse_gen
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic run_i,
   input wire logic [15:0] speed_i,
   input wire logic [11:0] mult_i,
   // pulse
   output logic pulse_o
);
   typedef struct packed
   {
      logic [11:0] pre;
      logic [15:0] acc;
      logic pulse;
   } pg_t;

   pg_t s_r;
   pg_t s_nxt;

   // *******************************************
   // rate = speed * fclk / ((mult + 1) * 65536)
   // *******************************************
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.pulse = 1'b0;
      if (!run_i)
      begin
         s_nxt.pre = '0;
         s_nxt.acc = '0;
      end
      else if (s_r.pre >= mult_i)
      begin
         s_nxt.pre = '0;
         {s_nxt.pulse, s_nxt.acc} = {1'b0, s_r.acc} + {1'b0, speed_i};
      end
      else
      begin
         s_nxt.pre = s_r.pre + 12'h1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign pulse_o = s_r.pulse;
endmodule

// ---- rtl/ramp_top_speed_correction.sv ----
// one axis speed profile with automatic top speed correction
`timescale 1ns/1ps
module ramp_top_speed_correction
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // motor driver
   output logic pulse_o,
   output logic busy_o
);
   import ramp_pkg::*;

   typedef struct packed
   {
      logic ack;
      logic [31:0] rdat;
      logic s_curve;
      logic corr_off;
      logic [2:0] idle_set;
      logic [15:0] top;
      logic [15:0] start;
      logic [15:0] urate;
      logic [15:0] drate;
      logic [14:0] sacc;
      logic [14:0] sdec;
      logic [23:0] move;
      logic [11:0] mult;
      logic [15:0] w_top;
      logic [15:0] w_urate;
      logic [15:0] w_drate;
      logic [14:0] w_sacc;
      logic [14:0] w_sdec;
      phase_t ph;
      logic [23:0] remain;
      logic [23:0] up;
      logic [2:0] lead;
      logic [15:0] speed;
      logic [19:0] step_cnt;
      logic corr;
      logic [15:0] corr_speed;
      logic [15:0] seg_t;
      logic [15:0] seg_b;
      logic stop_req;
      logic pulse;
      logic busy;
   } st_t;

   st_t s;
   st_t n;

   logic pulse_evt;
   logic wr_en;
   logic rd_en;
   logic start_go;
   logic finishing;
   logic [15:0] dr_eff;
   logic [16:0] ur_p1;
   logic [16:0] dr_p1;
   logic [47:0] rem_w;
   logic [47:0] up_w;
   logic decel_now;
   logic [15:0] tgt_now;
   logic [15:0] goal;
   logic rising;
   logic [15:0] span;
   logic [15:0] rng;
   logic s_zone;
   logic [16:0] rate_p1;
   logic [19:0] period;
   logic step_hit;

   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] dat,
                                          input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
            r[i*8 +: 8] = dat[i*8 +: 8];
      end
      return r;
   endfunction

   function automatic logic [15:0] absd(input logic [15:0] a, input logic [15:0] b);
      return (a > b) ? (a - b) : (b - a);
   endfunction

   // ***********************************************
   // pulse generator
   // ***********************************************
   pulse_gen u_pulse
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(s.ph != PH_IDLE),
      .speed_i(s.speed),
      .mult_i(s.mult),
      .pulse_o(pulse_evt)
   );

   // ***********************************************
   // profile arithmetic
   // ***********************************************
   assign wr_en = cyc_i && stb_i && we_i && !s.ack;
   assign rd_en = cyc_i && stb_i && !we_i && !s.ack;
   assign start_go = wr_en && (adr_i == ADDR_CTRL) && sel_i[0] && dat_i[CTRL_START_BIT]
                     && (s.ph == PH_IDLE) && (s.move != '0);
   assign finishing = pulse_evt && (s.ph != PH_IDLE) && (s.remain == 24'h1);
   // zero decel rate falls back to accel rate
   assign dr_eff = (s.w_drate == '0) ? s.w_urate : s.w_drate;
   assign ur_p1 = {1'b0, s.w_urate} + 17'h1;
   assign dr_p1 = {1'b0, dr_eff} + 17'h1;
   assign rem_w = 48'(s.remain) * 48'(ur_p1);
   assign up_w = 48'(s.up) * 48'(dr_p1);
   // decel point: distance left times (accel rate + 1) falls to distance used to accelerate times (decel rate + 1)
   assign decel_now = (s.ph == PH_RUN) && (s.stop_req || (rem_w <= up_w));
   assign tgt_now = decel_now ? s.start : (s.corr ? s.corr_speed : s.w_top);
   always_comb
   begin
      if (!s.s_curve)
         goal = (s.corr && !decel_now && (s.w_top < s.corr_speed)) ? s.w_top : tgt_now;
      else if (tgt_now < s.seg_t)
         goal = tgt_now;
      else
         goal = s.seg_t;
   end
   assign rising = s.speed < goal;
   assign span = absd(s.seg_t, s.seg_b);
   always_comb
   begin
      if (rising)
         rng = (s.w_sacc == '0) ? (span >> 1) : {1'b0, s.w_sacc};
      else
         rng = (s.w_sdec == '0) ? (span >> 1) : {1'b0, s.w_sdec};
   end
   // s zones near both ends of a segment step at half the rate
   assign s_zone = s.s_curve && ((absd(s.speed, s.seg_b) < rng)
                   || (absd(goal, s.speed) <= rng));
   assign rate_p1 = rising ? ur_p1 : dr_p1;
   assign period = {3'h0, rate_p1} << (STEP_SHIFT + int'(s_zone));
   assign step_hit = s.step_cnt >= (period - 20'h1);

   // ***********************************************
   // next state
   // ***********************************************
   always_comb
   begin
      n = s;
      n.ack = cyc_i && stb_i && !s.ack;
      n.pulse = pulse_evt;
      if (rd_en)
      begin
         if (adr_i == ADDR_CTRL)
            n.rdat = {30'h0, s.corr, s.ph != PH_IDLE};
         else if (adr_i == ADDR_MODE)
            n.rdat = {25'h0, s.idle_set, 2'h0, s.corr_off, s.s_curve};
         else if (adr_i == ADDR_TOP)
            n.rdat = {16'h0, s.top};
         else if (adr_i == ADDR_START)
            n.rdat = {16'h0, s.start};
         else if (adr_i == ADDR_URATE)
            n.rdat = {16'h0, s.urate};
         else if (adr_i == ADDR_DRATE)
            n.rdat = {16'h0, s.drate};
         else if (adr_i == ADDR_SACC)
            n.rdat = {17'h0, s.sacc};
         else if (adr_i == ADDR_SDEC)
            n.rdat = {17'h0, s.sdec};
         else if (adr_i == ADDR_MOVE)
            n.rdat = {8'h0, s.move};
         else if (adr_i == ADDR_MULT)
            n.rdat = {20'h0, s.mult};
         else if (adr_i == ADDR_SPEED)
            n.rdat = {16'h0, s.speed};
         else if (adr_i == ADDR_REMAIN)
            n.rdat = {8'h0, s.remain};
         else
            n.rdat = '0;
      end
      // live registers accept writes at any time
      if (wr_en)
      begin
         if (adr_i == ADDR_MODE)
         begin
            n.s_curve = dat_i[MODE_S_BIT];
            n.corr_off = dat_i[MODE_CORR_OFF_BIT];
            n.idle_set = dat_i[MODE_IDLE_MSB:MODE_IDLE_LSB];
         end
         else if (adr_i == ADDR_TOP)
            n.top = 16'(wmerge({16'h0, s.top}, dat_i, sel_i));
         else if (adr_i == ADDR_START)
            n.start = 16'(wmerge({16'h0, s.start}, dat_i, sel_i));
         else if (adr_i == ADDR_URATE)
            n.urate = 16'(wmerge({16'h0, s.urate}, dat_i, sel_i));
         else if (adr_i == ADDR_DRATE)
            n.drate = 16'(wmerge({16'h0, s.drate}, dat_i, sel_i));
         else if (adr_i == ADDR_SACC)
            n.sacc = 15'(wmerge({17'h0, s.sacc}, dat_i, sel_i));
         else if (adr_i == ADDR_SDEC)
            n.sdec = 15'(wmerge({17'h0, s.sdec}, dat_i, sel_i));
         else if (adr_i == ADDR_MOVE)
            n.move = 24'(wmerge({8'h0, s.move}, dat_i, sel_i));
         else if (adr_i == ADDR_MULT)
            n.mult = 12'(wmerge({20'h0, s.mult}, dat_i, sel_i));
         else if ((adr_i == ADDR_CTRL) && sel_i[0] && dat_i[CTRL_STOP_BIT]
                  && (s.ph != PH_IDLE))
            n.stop_req = 1'b1;
      end
      case (s.ph)
         PH_IDLE:
         begin
            if (start_go)
            begin
               n.speed = s.start;
               n.remain = s.move;
               n.up = '0;
               n.corr = 1'b0;
               n.stop_req = 1'b0;
               n.step_cnt = '0;
               n.w_top = s.top;
               n.w_urate = s.urate;
               n.w_drate = s.drate;
               n.w_sacc = s.sacc;
               n.w_sdec = s.sdec;
               n.seg_t = s.top;
               n.seg_b = s.start;
               if (s.idle_set >= IDLE_MIN)
               begin
                  n.lead = s.idle_set - 3'h1;
                  n.ph = PH_LEAD;
               end
               else
               begin
                  n.lead = '0;
                  n.ph = PH_RUN;
               end
            end
         end
         PH_LEAD:
         begin
            // idle pulses at start speed count against the move
            if (pulse_evt)
            begin
               n.remain = s.remain - 24'h1;
               n.lead = s.lead - 3'h1;
               if (s.lead == 3'h1)
                  n.ph = PH_RUN;
            end
         end
         PH_RUN:
         begin
            if (pulse_evt && rising)
               n.up = s.up + 24'h1;
            if (pulse_evt)
               n.remain = s.remain - 24'h1;
            if (!s.corr_off && !s.corr && rising && (rem_w <= (up_w << 1)))
            begin
               n.corr = 1'b1;
               n.corr_speed = s.speed;
            end
            // s-curve segment restarts from the present speed
            if (s.s_curve && (tgt_now != s.seg_t)
                && ((s.speed == s.seg_t) || (tgt_now < s.speed)))
            begin
               n.seg_t = tgt_now;
               n.seg_b = s.speed;
            end
            if (step_hit)
            begin
               n.step_cnt = '0;
               // live values are taken only at a speed step
               n.w_top = s.top;
               n.w_urate = s.urate;
               n.w_drate = s.drate;
               n.w_sacc = s.sacc;
               n.w_sdec = s.sdec;
               if (rising)
                  n.speed = s.speed + 16'h1;
               else if (s.speed > goal)
                  n.speed = s.speed - 16'h1;
            end
            else
               n.step_cnt = s.step_cnt + 20'h1;
            if (s.stop_req && (s.speed <= s.start))
               n.ph = PH_IDLE;
         end
         default:
            n.ph = PH_IDLE;
      endcase
      if (finishing || (n.ph == PH_IDLE && s.ph != PH_IDLE))
      begin
         n.ph = PH_IDLE;
         n.speed = '0;
         n.stop_req = 1'b0;
      end
      n.busy = (n.ph != PH_IDLE);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         s <= '0;
      else
         s <= n;
   end

   assign dat_o = s.rdat;
   assign ack_o = s.ack;
   assign pulse_o = s.pulse;
   assign busy_o = s.busy;

   // ***********************************************
   // assertions
   // ***********************************************
   property p_step_only;
      @(posedge clk_i) disable iff (rst_i)
      (s.ph == PH_RUN) && ($past(s.ph) == PH_RUN) && (s.speed != $past(s.speed))
      |-> $past(step_hit);
   endproperty
   a_step_only: assert property (p_step_only)
      else $error("speed changed off a step boundary");

   property p_lin_down;
      @(posedge clk_i) disable iff (rst_i)
      (s.ph == PH_RUN) && !s.s_curve && step_hit && !decel_now && !s.corr && !finishing
      && (s.speed > s.w_top) |=> (s.speed == $past(s.speed) - 16'h1);
   endproperty
   a_lin_down: assert property (p_lin_down)
      else $error("linear ramp did not step down to lowered top");

   property p_lin_up;
      @(posedge clk_i) disable iff (rst_i)
      (s.ph == PH_RUN) && !s.s_curve && step_hit && !decel_now && !s.corr && !finishing
      && (s.speed < s.w_top) |=> (s.speed == $past(s.speed) + 16'h1);
   endproperty
   a_lin_up: assert property (p_lin_up)
      else $error("linear ramp did not step up to new top");

   property p_corr_gate;
      @(posedge clk_i) disable iff (rst_i)
      $rose(s.corr) |-> ($past(s.corr_off) == 1'b0) && ($past(s.ph) == PH_RUN);
   endproperty
   a_corr_gate: assert property (p_corr_gate)
      else $error("correction applied while disabled");

   property p_lead;
      @(posedge clk_i) disable iff (rst_i)
      start_go && (s.idle_set >= IDLE_MIN)
      |=> (s.lead == $past(s.idle_set) - 3'h1) && (s.ph == PH_LEAD);
   endproperty
   a_lead: assert property (p_lead)
      else $error("idle pulse count wrong");

   property p_s_keep;
      @(posedge clk_i) disable iff (rst_i)
      (s.ph == PH_RUN) && s.s_curve && !decel_now && !s.corr && !finishing
      && (s.speed < s.seg_t) && (s.w_top > s.seg_t) |=> (s.seg_t == $past(s.seg_t));
   endproperty
   a_s_keep: assert property (p_s_keep)
      else $error("raised top disturbed running s-curve");

   property p_s_new;
      @(posedge clk_i) disable iff (rst_i)
      (s.ph == PH_RUN) && s.s_curve && !decel_now && !s.corr && !finishing
      && (s.w_top < s.speed) && (s.seg_t != s.w_top) |=> (s.seg_t == $past(s.w_top));
   endproperty
   a_s_new: assert property (p_s_new)
      else $error("no new s-curve for top below speed");

   property p_live_wr;
      @(posedge clk_i) disable iff (rst_i)
      wr_en && (adr_i == ADDR_TOP) && (sel_i == 4'hf) |=> (s.top == $past(dat_i[15:0]));
   endproperty
   a_live_wr: assert property (p_live_wr)
      else $error("top speed write lost");
endmodule

// ---- testbench/motor_model.sv ----
// behavioural motor driver that counts the step pulses it receives
`timescale 1ns/1ps
module motor_model
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // step input
   input wire logic clear_i,
   input wire logic pulse_i,
   // observation
   output logic [23:0] step_count_o,
   output logic wide_pulse_o
);
   logic pulse_q;
   always_ff @(posedge clk_i)
   begin
      pulse_q <= pulse_i;
      if (rst_i || clear_i)
      begin
         step_count_o <= 24'h000000;
         wide_pulse_o <= 1'b0;
      end
      else
      begin
         if (pulse_i)
            step_count_o <= step_count_o + 24'h000001;
         // a step longer than one clock would be seen twice by a real driver
         if (pulse_i && pulse_q)
            wide_pulse_o <= 1'b1;
      end
   end
endmodule

// ---- testbench/tb_ramp_top_speed_correction.sv ----
// self-checking bench for the ramp top speed correction block
`timescale 1ns/1ps
module tb_ramp_top_speed_correction;
   import ramp_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h00000000;
   logic [31:0] dat_o;
   logic ack_o;
   logic pulse_o;
   logic busy_o;
   logic clear_r = 1'b0;
   logic [23:0] steps;
   logic wide;
   logic [31:0] rd;
   int n_fail = 0;
   int samples_checked = 0;
   int cycles = 0;
   int pk;

   ramp_top_speed_correction dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .pulse_o(pulse_o), .busy_o(busy_o));
   motor_model drive (.clk_i(clk_i), .rst_i(rst_i), .clear_i(clear_r), .pulse_i(pulse_o),
      .step_count_o(steps), .wide_pulse_o(wide));

   // ***********************************************
   // clock and watchdog
   // ***********************************************
   always #25 clk_i = ~clk_i;
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 90000)
      begin
         n_fail = n_fail + 1;
         complete_run();
      end
   end

   // ***********************************************
   // tasks
   // ***********************************************
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // classic wishbone single cycle; read data lands in rd
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hf;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack_o !== 1'b1 && n < 50);
      check({31'h0, ack_o}, 32'h1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask

   // poll the live speed until it lies in lo..hi, tracking the peak
   task automatic await_speed(input int lo, input int hi);
      int t0;
      t0 = cycles;
      pk = 0;
      do
      begin
         wb(1'b0, ADDR_SPEED, 32'h0);
         if (int'(rd[15:0]) > pk)
            pk = int'(rd[15:0]);
      end
      while ((int'(rd[15:0]) < lo || int'(rd[15:0]) > hi) && cycles - t0 < 8000);
      check({31'h0, int'(rd[15:0]) >= lo && int'(rd[15:0]) <= hi}, 32'h1);
   endtask

   task automatic wait_idle;
      int t0;
      t0 = cycles;
      @(posedge clk_i);
      while (busy_o !== 1'b0 && cycles - t0 < 20000)
      begin
         wb(1'b0, ADDR_SPEED, 32'h0);
         if (int'(rd[15:0]) > pk)
            pk = int'(rd[15:0]);
      end
      @(posedge clk_i);
      check({31'h0, busy_o}, 32'h0);
   endtask

   // short move of 30 steps; drate 0 follows urate, so decel time stays within twice accel
   task automatic short_move(input logic [31:0] mode, input int top);
      wb(1'b1, ADDR_MODE, mode);
      wb(1'b1, ADDR_TOP, top);
      wb(1'b1, ADDR_URATE, 32'h0);
      wb(1'b1, ADDR_DRATE, 32'h0);
      clear_r <= 1'b1;
      wb(1'b1, ADDR_MOVE, 32'd30);
      clear_r <= 1'b0;
      wb(1'b1, ADDR_CTRL, 32'h1);
      pk = 0;
      wait_idle();
      check({8'h0, steps}, 32'd30);
   endtask

   // linear or s-curve ramp with live top speed changes, then a stop
   task automatic ramp_live(input logic s);
      int t0;
      int d;
      wb(1'b1, ADDR_MODE, {31'h0, s});
      wb(1'b1, ADDR_TOP, 32'd1050);
      wb(1'b1, ADDR_URATE, 32'd3);
      wb(1'b1, ADDR_MOVE, 32'h000fffff);
      wb(1'b1, ADDR_CTRL, 32'h1);
      t0 = cycles;
      await_speed(1050, 1050);
      d = cycles - t0 - 50 * 4 * (s ? 8 : 4);
      check({31'h0, d >= -40 && d <= 40}, 32'h1);
      wb(1'b1, ADDR_TOP, 32'd1080);
      await_speed(1080, 1080);
      check({31'h0, pk <= 1080}, 32'h1);
      wb(1'b1, ADDR_TOP, 32'd1200);
      await_speed(1100, 16'hffff);
      wb(1'b1, ADDR_TOP, 32'd1150);
      await_speed(1150, 1150);
      repeat (4) wb(1'b0, ADDR_SPEED, 32'h0);
      check({16'h0, rd[15:0]}, 32'd1150);
      wb(1'b1, ADDR_TOP, 32'd1300);
      await_speed(1200, 16'hffff);
      wb(1'b1, ADDR_TOP, 32'd1180);
      await_speed(1180, 1180);
      wb(1'b1, ADDR_CTRL, 32'h2);
      wait_idle();
   endtask

   // highest top speed that avoids a triangle for a 30 step move, mult 0, rates 0;
   // k is the rate sum term: 2 for linear, doubled for s-curve without linear part
   function automatic int top_limit(input int start, input int k);
      int t;
      t = start;
      while (((t + 1) * (t + 1) - start * start) * k <= 32768 * 30)
         t++;
      return t;
   endfunction

   // s ranges to clear for a short s-curve move from start 1000, rates 0, mult 0:
   // bit1 clears the accel range, bit0 the decel range
   function automatic logic [1:0] s_clear(input int sa, input int sd, input int mv);
      int sm;
      sm = (sa < sd) ? sa : sd;
      if (mv * 32768 <= (sm + 1000) * sm * 2 * 8)
         return 2'b11;
      else if (sa < sd)
         return 2'b01;
      else if (sa > sd)
         return 2'b10;
      else
         return 2'b00;
   endfunction

   // ***********************************************
   // main sequence
   // ***********************************************
   initial
   begin
      int lim;
      logic [1:0] sc;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int a = 0; a <= 8'h2c; a += 4)
      begin
         wb(1'b0, 8'(a), 32'h0);
         check(rd, 32'h0);
      end
      wb(1'b0, 8'h40, 32'h0);
      check(rd, 32'h0);
      wb(1'b1, ADDR_SPEED, 32'h00001234);
      wb(1'b0, ADDR_SPEED, 32'h0);
      check(rd, 32'h0);
      wb(1'b1, ADDR_START, 32'd1000);
      wb(1'b1, ADDR_MULT, 32'h0);
      $display("registers test done");
      short_move(32'h00000000, 3000);
      check({31'h0, pk < 3000}, 32'h1);
      wb(1'b0, ADDR_CTRL, 32'h0);
      check(rd, 32'h2);
      short_move(32'h00000070, 3000);
      lim = top_limit(1000, 2);
      short_move(32'h00000002, lim);
      check({31'h0, pk <= lim && pk >= lim - 10}, 32'h1);
      wb(1'b0, ADDR_CTRL, 32'h0);
      check(rd, 32'h0);
      wb(1'b1, ADDR_SACC, 32'd100);
      wb(1'b1, ADDR_SDEC, 32'd200);
      sc = s_clear(100, 200, 30);
      check({30'h0, sc}, 32'h3);
      wb(1'b1, ADDR_SACC, sc[1] ? 32'h0 : 32'd100);
      wb(1'b1, ADDR_SDEC, sc[0] ? 32'h0 : 32'd200);
      lim = top_limit(1000, 4);
      short_move(32'h00000003, lim);
      check({31'h0, pk <= lim && pk >= lim - 10}, 32'h1);
      $display("short move tests done");
      ramp_live(1'b0);
      $display("linear ramp test done");
      ramp_live(1'b1);
      $display("s-curve ramp test done");
      check({31'h0, wide}, 32'h0);
      complete_run();
   end
endmodule
